// File: plcr_defs.vh
// Constants for the phy-side control pair encoder and request line decoder.
`ifndef PLCR_DEFS_VH
`define PLCR_DEFS_VH
// ****************************************************************
// Control pair encodings
// ****************************************************************
`define PLCR_CTL_IDLE     2'h0
`define PLCR_CTL_STATUS   2'h1
`define PLCR_CTL_RECEIVE  2'h2
`define PLCR_CTL_GRANT    2'h3
`define PLCR_LCTL_IDLE    2'h0
`define PLCR_LCTL_HOLD    2'h1
`define PLCR_LCTL_XMIT    2'h2
`define PLCR_LCTL_RSVD    2'h3
// ****************************************************************
// Request stream layout
// ****************************************************************
`define PLCR_LEN_BUS      5'h07
`define PLCR_LEN_READ     5'h09
`define PLCR_LEN_WRITE    5'h11
`define PLCR_POS_TYPE_END 5'h03
`define PLCR_TYP_IMM      3'h0
`define PLCR_TYP_ISO      3'h1
`define PLCR_TYP_PRI      3'h2
`define PLCR_TYP_FAIR     3'h3
`define PLCR_TYP_READ     3'h4
`define PLCR_TYP_WRITE    3'h5
`define PLCR_STATUS_BITS  4'h8
`define PLCR_SPEED_100    2'h0
`define PLCR_SYNC_LAG     2'h3
`endif

// File: plcr_phy_link_ctl.v
// Phy side of the phy-to-link control pair and serial request line.
`include "plcr_defs.vh"
`default_nettype none
// Summary of operation
// [R1] Phy drives 00 on control pair when interface is idle.
// [R2] Phy drives 01 while sending status to the link.
// [R3] Phy drives 10 while forwarding a received packet.
// [R4] Phy drives 11 to grant the link the interface.
// [R5] Link drives control and data only after the phy grants.
// [R6] Link drives 00 to release the interface when done.
// [R7] Link drives 01 to hold the interface.
// [R8] Link drives 10 while sending an outgoing packet.
// [R9] Link never drives 11; phy gives it no meaning.
// [R10] Request stream starts with bit 1 and ends with bit 0.
// [R11] Bit 0 is sent first; fields assemble in that order.
// [R12] Link keeps request line low outside a stream.
// [R13] Streams are 7, 9 or 17 bits for bus, read, write.
// [R14] Bus request: type in bits 1-3, speed 00 in bits 4-5.
// [R15] Read: type 100, address bits 4-7, stop at 8.
// [R16] Write: type 101, address 4-7, data 8-15, stop at 16.
// [R17] Immediate type 000: take cable without arbitration on idle.
// [R18] Isochronous type 001: arbitrate with no gap.
// [R19] Priority type 010: arbitrate after subaction gap, no fairness.
// [R20] Fair type 011: arbitrate after subaction gap, with fairness.
// [R21] Read request returns the addressed register by status transfer.
// [R22] Request line sampled once per clock, one bit per clock.
// [R23] Reserved types 110 and 111 are ignored; here they still clear a pending isochronous request.
// [R24] Write loads data into register after the whole stream.
// [R25] Status transfer starts only at idle with 01 and first bits.
module plcr_phy_link_ctl (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        linkRequestLine,
  input  wire [1:0]  lineControlIn,
  output reg  [1:0]  lineControlOut,
  output wire        lineControlOeN,
  input  wire [1:0]  dataLineIn,
  output reg  [1:0]  dataLineOut,
  output wire        dataLineOeN,
  input  wire        cableIdle,
  input  wire        subactionGap,
  input  wire        receiveActive,
  input  wire        arbWon,
  input  wire [3:0]  statusFlags,
  output reg         reqImmediate,
  output reg         reqIsochronous,
  output reg         reqPriority,
  output reg         reqFair,
  output reg         arbStart,
  output reg         arbUseFairness,
  output reg  [3:0]  regWriteAddr,
  output reg  [7:0]  regWriteData,
  output reg         regWriteStrobe,
  output reg  [3:0]  regReadAddr,
  input  wire [7:0]  regReadData,
  output reg         linkOwnsBus,
  output reg  [1:0]  linkCtlSeen,
  output reg         linkCtlBad
);

// ****************************************************************
// Input synchronisers
// ****************************************************************
  // Request line and link-driven pins come from another chip.
  reg        lreqMeta_q, lreqSync_q;
  reg  [1:0] ctlMeta_q, ctlSync_q;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lreqMeta_q <= 1'b0;
      lreqSync_q <= 1'b0;
      ctlMeta_q  <= 2'h0;
      ctlSync_q  <= 2'h0;
    end else begin
      lreqMeta_q <= linkRequestLine;
      lreqSync_q <= lreqMeta_q;  // [R22]
      ctlMeta_q  <= lineControlIn;
      ctlSync_q  <= ctlMeta_q;
    end
  end

// ****************************************************************
// Request stream receiver
// ****************************************************************
  reg        rxBusy_q;
  reg  [4:0] rxCnt_q;
  reg  [15:0] rxSh_q;
  wire [15:0] rxShD = {rxSh_q[14:0], lreqSync_q};  // [R11]
  wire [2:0]  typNow = rxSh_q[2:0];
  // The type is latched once its three bits are in, since later bits shift past it.
  reg  [2:0]  rxTyp_q;
  wire [4:0]  rxLen = (rxTyp_q == `PLCR_TYP_READ)  ? `PLCR_LEN_READ :
                      (rxTyp_q == `PLCR_TYP_WRITE) ? `PLCR_LEN_WRITE : `PLCR_LEN_BUS;  // [R13]
  wire rxLast = rxBusy_q && (rxCnt_q > `PLCR_POS_TYPE_END + 5'h01) &&
                (rxCnt_q == rxLen - 5'h01);
  // Request decode is done once the stop bit arrives; its value is not checked
  // because a missing stop bit cannot be repaired and the frame is already counted.
  reg  [15:0] done_q;
  reg         doneV_q;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxBusy_q <= 1'b0;
      rxCnt_q  <= 5'h00;
      rxSh_q   <= 16'h0000;
      rxTyp_q  <= 3'h0;
      done_q   <= 16'h0000;
      doneV_q  <= 1'b0;
    end else begin
      doneV_q <= 1'b0;
      if (!rxBusy_q) begin
        rxCnt_q <= 5'h01;
        rxSh_q  <= 16'h0000;
        if (lreqSync_q)
          rxBusy_q <= 1'b1;  // [R10] [R12]
      end else if (rxLast) begin
        rxBusy_q <= 1'b0;  // [R10]
        done_q   <= rxSh_q;
        doneV_q  <= 1'b1;
      end else begin
        rxCnt_q <= rxCnt_q + 5'h01;
        rxSh_q  <= rxShD;
        if (rxCnt_q == `PLCR_POS_TYPE_END + 5'h01)
          rxTyp_q <= typNow;
      end
    end
  end
  // Stored bits: 15 bits max; after a bus request [4:0] holds type then speed.
  wire [2:0] typBus  = done_q[4:2];  // [R14]
  // Bit counts of the finished frame tell the kinds apart; the type field then confirms.
  reg  [4:0] rxBusyLen;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      rxBusyLen <= 5'h00;
    else if (rxLast)
      rxBusyLen <= rxCnt_q + 5'h01;
  end
  wire [2:0] typRd = done_q[6:4];
  wire [2:0] typWr = done_q[14:12];
  localparam ST_IDLE = 2'h0;
  localparam ST_STAT = 2'h1;
  localparam ST_GAP  = 2'h2;
  localparam ST_LINK = 2'h3;
  reg  [1:0]  state_q;
  reg  [3:0]  statCnt_q;
  wire rdStart  = (state_q == ST_IDLE) && rdPend_q && !receiveActive && !arbWon;
  // A read stays pending until its status transfer completes, so an aborted one is retried.
  wire rdDone   = (state_q == ST_STAT) && (statCnt_q == `PLCR_STATUS_BITS) && !receiveActive;
  wire immGrant = (state_q == ST_IDLE) && reqImmediate && cableIdle;

// ****************************************************************
// Request actions
// ****************************************************************
  reg        statPend_q;
  reg        rdPend_q;
  reg  [7:0] rdData_q;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reqImmediate   <= 1'b0;
      reqIsochronous <= 1'b0;
      reqPriority    <= 1'b0;
      reqFair        <= 1'b0;
      arbStart       <= 1'b0;
      arbUseFairness <= 1'b0;
      regWriteAddr   <= 4'h0;
      regWriteData   <= 8'h00;
      regWriteStrobe <= 1'b0;
      regReadAddr    <= 4'h0;
      rdPend_q       <= 1'b0;
    end else begin
      regWriteStrobe <= 1'b0;
      arbStart       <= 1'b0;
      if (doneV_q) begin
        if (rxBusyLen == `PLCR_LEN_WRITE && typWr == `PLCR_TYP_WRITE) begin
          regWriteAddr   <= done_q[11:8];
          regWriteData   <= done_q[7:0];
          regWriteStrobe <= 1'b1;  // [R16] [R24]
        end else if (rxBusyLen == `PLCR_LEN_READ && typRd == `PLCR_TYP_READ) begin
          regReadAddr <= done_q[3:0];
          rdPend_q    <= 1'b1;  // [R15] [R21]
        end else if (rxBusyLen == `PLCR_LEN_BUS) begin
          reqIsochronous <= 1'b0;
          case (typBus)
            `PLCR_TYP_IMM:  reqImmediate   <= 1'b1;  // [R17]
            `PLCR_TYP_ISO:  reqIsochronous <= 1'b1;  // [R18]
            `PLCR_TYP_PRI:  reqPriority    <= 1'b1;  // [R19]
            `PLCR_TYP_FAIR: reqFair        <= 1'b1;  // [R20]
            default: ;  // [R23]
          endcase
        end
      end else begin
        if (immGrant)
          reqImmediate <= 1'b0;  // [R17]
        if (reqIsochronous && !arbStart) begin
          arbStart       <= 1'b1;  // [R18]
          arbUseFairness <= 1'b0;
        end
        if ((reqPriority || reqFair) && subactionGap && !receiveActive && !arbStart) begin
          arbStart       <= 1'b1;
          arbUseFairness <= reqFair;  // [R19] [R20]
        end
        if (arbWon) begin
          reqIsochronous <= 1'b0;
          reqPriority    <= 1'b0;
          reqFair        <= 1'b0;
        end
        if (receiveActive) begin
          reqPriority <= 1'b0;
          reqFair     <= 1'b0;
        end
        if (rdDone)
          rdPend_q <= 1'b0;
      end
    end
  end

// ****************************************************************
// Control pair driver and status transfer
// ****************************************************************
  reg  [15:0] statSh_q;
  reg  [1:0]  linkAge_q;
  // The grant is driven for one cycle before the pins are handed to the link.
  assign lineControlOeN = (state_q == ST_LINK) && (lineControlOut != `PLCR_CTL_GRANT);  // [R5]
  assign dataLineOeN    = lineControlOeN;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q        <= ST_IDLE;
      statCnt_q      <= 4'h0;
      statSh_q       <= 16'h0000;
      linkAge_q      <= 2'h0;
      lineControlOut <= `PLCR_CTL_IDLE;
      dataLineOut    <= 2'h0;
      linkOwnsBus    <= 1'b0;
      linkCtlSeen    <= `PLCR_LCTL_IDLE;
      linkCtlBad     <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          lineControlOut <= `PLCR_CTL_IDLE;  // [R1]
          dataLineOut    <= 2'h0;
          if (arbWon || immGrant) begin
            lineControlOut <= `PLCR_CTL_GRANT;  // [R4] [R17]
            state_q        <= ST_LINK;
            linkCtlSeen    <= `PLCR_LCTL_IDLE;
            linkAge_q      <= 2'h0;
          end else if (receiveActive) begin
            lineControlOut <= `PLCR_CTL_RECEIVE;  // [R3]
          end else if (rdStart) begin
            statSh_q       <= {statusFlags, regReadAddr, regReadData};
            lineControlOut <= `PLCR_CTL_STATUS;  // [R2] [R25]
            dataLineOut    <= statusFlags[3:2];
            statCnt_q      <= 4'h1;
            state_q        <= ST_STAT;
          end
        end
        ST_STAT: begin
          if (receiveActive) begin
            lineControlOut <= `PLCR_CTL_RECEIVE;  // [R3]
            state_q        <= ST_GAP;
          end else if (statCnt_q == `PLCR_STATUS_BITS) begin
            lineControlOut <= `PLCR_CTL_IDLE;
            state_q        <= ST_GAP;
          end else begin
            lineControlOut <= `PLCR_CTL_STATUS;  // [R2]
            dataLineOut    <= statSh_q[15 - {statCnt_q, 1'b0} -: 2];
            statCnt_q      <= statCnt_q + 4'h1;
          end
        end
        ST_GAP: begin
          // One idle cycle between status transfers; an aborted transfer is retried.
          lineControlOut <= receiveActive ? `PLCR_CTL_RECEIVE : `PLCR_CTL_IDLE;
          if (!receiveActive)
            state_q <= ST_IDLE;
        end
        ST_LINK: begin
          // The synchroniser still shows the phy's own grant for a few cycles; skip those.
          lineControlOut <= `PLCR_CTL_IDLE;
          if (lineControlOut == `PLCR_CTL_GRANT)
            linkOwnsBus <= 1'b1;
          if (linkAge_q != `PLCR_SYNC_LAG) begin
            linkAge_q <= linkAge_q + 2'h1;
          end else begin
            linkCtlSeen <= ctlSync_q;
            linkCtlBad  <= (ctlSync_q == `PLCR_LCTL_RSVD);  // [R9]
            if (ctlSync_q == `PLCR_LCTL_IDLE && linkCtlSeen != `PLCR_LCTL_IDLE) begin
              state_q     <= ST_IDLE;  // [R6]
              linkOwnsBus <= 1'b0;
            end
          end
          // Hold [R7] and transmit [R8] keep ownership with the link.
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: plcr_ctl_props.sv
// Checker for the phy control pair and request handling.
`include "plcr_defs.vh"
`default_nettype none
module plcr_ctl_props (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [1:0] lineControlIn,
  input wire logic [1:0] lineControlOut,
  input wire logic       lineControlOeN,
  input wire logic       dataLineOeN,
  input wire logic       receiveActive,
  input wire logic       reqImmediate,
  input wire logic       reqIsochronous,
  input wire logic       reqPriority,
  input wire logic       reqFair,
  input wire logic       arbStart,
  input wire logic       regWriteStrobe,
  input wire logic       linkOwnsBus,
  input wire logic       linkCtlBad
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_oe_pair_same: assert property (lineControlOeN == dataLineOeN)
    else $error("pair enables differ");
  a_oe_link_own: assert property (linkOwnsBus == lineControlOeN)
    else $error("phy drives while link owns");
  a_strobe_single: assert property (regWriteStrobe |=> !regWriteStrobe)
    else $error("write strobe too long");
  a_arb_single: assert property (arbStart |=> !arbStart)
    else $error("arbitration start too long");
  a_status_after_idle: assert property (!lineControlOeN && $past(lineControlOeN) == 1'b0 &&
    lineControlOut == `PLCR_CTL_STATUS && $past(lineControlOut) != `PLCR_CTL_STATUS
    |-> $past(lineControlOut) == `PLCR_CTL_IDLE) else $error("status not from idle");
  a_grant_has_cause: assert property (!lineControlOeN && lineControlOut == `PLCR_CTL_GRANT
    && $past(lineControlOut) != `PLCR_CTL_GRANT |-> $past(reqImmediate) || $past(reqFair)
    || $past(reqIsochronous) || $past(reqPriority)) else $error("grant without request");
  a_receive_shown: assert property ($rose(receiveActive) && !linkOwnsBus &&
    lineControlOut == `PLCR_CTL_IDLE |-> ##[1:3] lineControlOut == `PLCR_CTL_RECEIVE)
    else $error("receive not shown");
  a_rsvd_flagged: assert property (linkOwnsBus && $past(linkOwnsBus) &&
    lineControlIn == `PLCR_LCTL_RSVD |-> ##[0:3] linkCtlBad) else $error("reserved unflagged");
endmodule
bind plcr_phy_link_ctl plcr_ctl_props u_props (.*);
`default_nettype wire

// File: plcr_link_model.sv
// Link model: request frames and control pair ownership after a grant.
`include "plcr_defs.vh"
`default_nettype none
module plcr_link_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] lineControlOut,
  input  wire logic       lineControlOeN,
  input  wire logic [1:0] dataLineOut,
  output var  logic       linkRequestLine,
  output wire logic [1:0] lineControlIn,
  output wire logic [1:0] dataLineIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       ownQ;
  logic       badCtl = 1'b0;
  logic [1:0] drvQ;
  logic [3:0] cntQ;
  initial linkRequestLine = 1'b0;
  // The phy's value stands on the wires while its enable is low.
  assign lineControlIn = lineControlOeN ? drvQ : lineControlOut;
  assign dataLineIn    = lineControlOeN ? cntQ[1:0] : dataLineOut;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ownQ <= 1'b0;
      cntQ <= 4'h0;
      drvQ <= `PLCR_LCTL_IDLE;
    end else begin
      // Take the bus only on a grant, hold, send, then release.
      ownQ <= ownQ ? cntQ != 4'h7 : lineControlOut == `PLCR_CTL_GRANT && !lineControlOeN;
      cntQ <= ownQ ? cntQ + 4'h1 : 4'h0;
      drvQ <= (!ownQ || cntQ > 4'h5) ? `PLCR_LCTL_IDLE : (cntQ > 4'h1) ? `PLCR_LCTL_XMIT :
              badCtl ? `PLCR_LCTL_RSVD : `PLCR_LCTL_HOLD;
    end
  end
  task automatic send(input logic [16:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      linkRequestLine <= f[i];
      @(posedge clk);
    end
    linkRequestLine <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: plcr_phy_link_ctl_tb_top.sv
// Testbench for the phy control pair and request line logic.
`include "plcr_defs.vh"
`default_nettype none
module plcr_phy_link_ctl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, sys_rst, linkRequestLine, lineControlOeN, dataLineOeN, cableIdle;
  logic        subactionGap, receiveActive, arbWon, arbStart, arbUseFairness, fairSeen = 0;
  logic        reqImmediate, reqIsochronous, reqPriority, reqFair, regWriteStrobe;
  logic        linkOwnsBus, linkCtlBad;
  logic [1:0]  lineControlIn, lineControlOut, dataLineIn, dataLineOut, linkCtlSeen;
  logic [3:0]  statusFlags, regWriteAddr, regReadAddr, a, reqs;
  logic [7:0]  regWriteData, regReadData, d;
  logic [15:0] s;
  int          failCount = 0, nCompared = 0, cyc = 0, arbN = 0, badN = 0, n0, b0;
  plcr_phy_link_ctl dut (.*);
  plcr_link_model lm (.*);
  assign reqs = {reqImmediate, reqIsochronous, reqPriority, reqFair};
  assign regReadData = {regReadAddr, ~regReadAddr};
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [16:0] frm(input logic [2:0] t, input logic [11:0] v);
    logic [16:0] f;
    f = 17'h00001;
    for (int i = 0; i < 3; i++) f[3 - i] = t[i];
    for (int i = 0; i < 12; i++) f[15 - i] = v[i];
    return f;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      failCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    if (arbStart) fairSeen <= arbUseFairness;
    arbN <= arbN + int'(arbStart);
    badN <= badN + int'(linkCtlBad);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failCount++;
      give_verdict();
    end
  end
  initial begin
    {sys_rst, cableIdle, subactionGap, receiveActive, arbWon, statusFlags} = 9'h100;
    void'($urandom(54875));
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    statusFlags <= 4'($urandom);
    @(posedge clk);
    chk(16'({lineControlOut, lineControlOeN}), 16'h0000);
    for (int k = 0; k < 4; k++) begin
      a = 4'($urandom);
      d = 8'($urandom);
      lm.send(frm(`PLCR_TYP_WRITE, {a, d}), 17);
      repeat (8) if (!regWriteStrobe) @(posedge clk);
      chk({regWriteStrobe, 3'h0, regWriteAddr, regWriteData}, {4'h8, a, d});
    end
    a = 4'($urandom);
    lm.send(frm(`PLCR_TYP_READ, {a, 8'h00}), 9);
    repeat (12) if (lineControlOut != `PLCR_CTL_STATUS) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      chk(16'({lineControlOut, dataLineOeN}), 16'h0002);
      s = {s[13:0], dataLineOut};
      @(posedge clk);
    end
    chk({4'h0, s[11:0]}, {4'h0, a, a, ~a});
    for (int t = 0; t < 4; t++) begin
      lm.badCtl <= (t == 1);
      n0 = arbN;
      b0 = badN;
      lm.send(frm(3'(t), 12'h000), 7);
      repeat (8) if (reqs == 4'h0) @(posedge clk);
      chk(16'(reqs), 16'(4'h8 >> t));
      {cableIdle, subactionGap, arbWon} <= {2'h3, t != 0};
      repeat (20) if (lineControlOut != `PLCR_CTL_GRANT) @(posedge clk);
      arbWon <= 1'b0;
      chk(16'(lineControlOut), 16'(`PLCR_CTL_GRANT));
      repeat (20) if (!linkOwnsBus) @(posedge clk);
      repeat (20) if (linkOwnsBus) @(posedge clk);
      chk(16'({arbN != n0, fairSeen, badN != b0, reqs}), 16'({t != 0, t == 3, t == 1, 4'h0}));
      {cableIdle, subactionGap, arbWon} <= 3'h0;
    end
    for (int t = 6; t < 8; t++) begin
      lm.send(frm(3'(t), 12'h000), 7);
      repeat (8) @(posedge clk);
      chk(16'({reqs, regWriteStrobe}), 16'h0000);
    end
    receiveActive <= 1'b1;
    repeat (3) @(posedge clk);
    chk(16'(lineControlOut), 16'(`PLCR_CTL_RECEIVE));
    lm.send(frm(`PLCR_TYP_PRI, 12'h000), 7);
    repeat (6) @(posedge clk);
    chk(16'(reqs), 16'h0000);
    receiveActive <= 1'b0;
    repeat (4) @(posedge clk);
    give_verdict();
  end
endmodule
`default_nettype wire
